//--- bench/line_ctrl_model.sv
// Line controller model driving the external request levels
`timescale 1ns/1ps
module line_ctrl_model (
  input wire clk_sys,
  output reg print_go_input,
  output reg print_again_input,
  output reg dispense_req_input
);
  initial begin
    print_go_input = 1'b0;
    print_again_input = 1'b0;
    dispense_req_input = 1'b0;
  end
  // Held six cycles so the two-stage synchroniser cannot miss it
  task automatic strike(input logic [1:0] sel);
    @(posedge clk_sys);
    print_go_input <= (sel == 2'h0);
    print_again_input <= (sel == 2'h1);
    dispense_req_input <= (sel == 2'h2);
    repeat (6) @(posedge clk_sys);
    {print_go_input, print_again_input, dispense_req_input} <= 3'h0;
    repeat (4) @(posedge clk_sys);
  endtask
endmodule // line_ctrl_model

//--- bench/print_signal_ctrl_bench.sv
// Self-checking bench for the print signal controller
`timescale 1ns/1ps
module print_signal_ctrl_bench;
  logic clk_sys = 0, srst = 1, wr_en = 0, rd_en = 0, print_start = 0, print_end = 0;
  logic quantity_remaining = 0, command_error = 0, online_toggle = 0;
  logic engine_ready = 1, at_home = 1;
  logic [3:0] addr = 0;
  logic [31:0] wdata = 0, c;
  wire [31:0] rdata;
  wire print_go_input, print_again_input, dispense_req_input, print_done_output;
  wire online_output, printer_ready_output, home_position_output;
  wire start_print, start_reprint, dispense_go, head_check;
  int n_errors = 0, total_checks = 0;
  logic [31:0] cnt [4] = '{default: 0};
  logic [19:0] r;
  // Cfg, then qty/err/input select, then expected pulse count
  logic [19:0] rows [12] = '{20'h05101, 20'h05180, 20'h04100, 20'h01100, 20'h04911,
    20'h04990, 20'h06991, 20'h069d0, 20'h04110, 20'h06190, 20'h20021, 20'h00020};
  print_signal_ctrl dut (.clk_sys, .srst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .print_go_input, .print_again_input, .dispense_req_input, .print_start, .print_end,
    .quantity_remaining, .command_error, .online_toggle, .engine_ready, .at_home,
    .print_done_output, .online_output, .printer_ready_output, .home_position_output,
    .start_print, .start_reprint, .dispense_go, .head_check);
  line_ctrl_model line (.clk_sys, .print_go_input, .print_again_input, .dispense_req_input);
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cnt[0] <= cnt[0] + start_print;
    cnt[1] <= cnt[1] + start_reprint;
    cnt[2] <= cnt[2] + dispense_go;
    cnt[3] <= cnt[3] + head_check;
  end
  // ----------
  // Tasks
  // ----------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    // Registered outputs follow the new setting one edge later
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 check(rdata, exp);
  endtask
  task automatic engine(input bit fin, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      if (fin) print_end <= 1'b1;
      else print_start <= 1'b1;
      @(posedge clk_sys);
      print_end <= 1'b0;
      print_start <= 1'b0;
      tick(3);
    end
  endtask
  task automatic head(input logic [31:0] cfg, input int n, input int exp);
    c = cnt[3];
    wr(4'h0, cfg);
    engine(1'b1, n);
    check(cnt[3] - c, exp);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Whole run is well under 2000 cycles; this is ample margin
  initial begin
    #100000;
    n_errors++;
    end_of_test;
  end
  // ----------
  // Sequence
  // ----------
  initial begin
    tick(12);
    srst <= 1'b0;
    tick(2);
    rd(4'h1, 32'h1);
    wr(4'h1, 32'h0);
    rd(4'h1, 32'h1);
    wr(4'h1, 32'hf4240);
    rd(4'h1, 32'h1);
    wr(4'h1, 32'hf423f);
    rd(4'h1, 32'hf423f);
    wr(4'h1, 32'h3);
    rd(4'h3, 32'h0);
    wr(4'h5, 32'h1);
    rd(4'h5, 32'h0);
    head(32'h80, 6, 2);
    head(32'h0, 2, 2);
    head(32'h180, 2, 0);
    head(32'h100, 2, 2);
    wr(4'h2, 32'h3);
    @(posedge clk_sys);
    online_toggle <= 1'b1;
    tick(6);
    online_toggle <= 1'b0;
    tick(6);
    #1 check(online_output, 1);
    for (int i = 0; i < 12; i++) begin
      r = rows[i];
      wr(4'h0, {20'h0, r[19:8]});
      quantity_remaining <= r[7];
      command_error <= r[6];
      tick(6);
      c = cnt[r[5:4]];
      line.strike(r[5:4]);
      #1 check(cnt[r[5:4]] - c, r[3:0]);
      check(home_position_output, r[17]);
      check(printer_ready_output, 0);
    end
    @(posedge clk_sys);
    command_error <= 1'b0;
    wr(4'h0, 32'h47);
    #1 check(print_done_output, 0);
    engine(1'b0, 1);
    #1 check(print_done_output, 1);
    engine(1'b1, 1);
    #1 check(print_done_output, 0);
    wr(4'h0, 32'h45);
    #1 check(print_done_output, 1);
    engine(1'b0, 1);
    #1 check(print_done_output, 0);
    engine(1'b1, 1);
    #1 check(print_done_output, 1);
    wr(4'h0, 32'h41);
    #1 check(print_done_output, 0);
    wr(4'h0, 32'h43);
    #1 check(print_done_output, 1);
    wr(4'h0, 32'h40);
    #1 check(print_done_output, 0);
    @(posedge clk_sys);
    srst <= 1'b1;
    tick(3);
    srst <= 1'b0;
    tick(3);
    #1 check(online_output, 0);
    check(printer_ready_output, 0);
    wr(4'h0, 32'h41);
    tick(2);
    #1 check(print_done_output, 1);
    // Auto online set, then a power cycle brings the kept settings in
    wr(4'h0, 32'h441);
    @(posedge clk_sys);
    srst <= 1'b1;
    tick(3);
    srst <= 1'b0;
    tick(3);
    #1 check(online_output, 1);
    check(printer_ready_output, 1);
    check(print_done_output, 0);
    end_of_test;
  end
endmodule // print_signal_ctrl_bench

//--- bench/print_signal_ctrl_sva.sv
// Port checks for the print signal controller
`timescale 1ns/1ps
module print_signal_ctrl_sva (
  input wire clk_sys,
  input wire srst,
  input wire rd_en,
  input wire [31:0] rdata,
  input wire command_error,
  input wire online_output,
  input wire start_print,
  input wire start_reprint,
  input wire dispense_go
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // ----------
  // Properties
  // ----------
  // Error held past the sync and edge stages, so the decision saw it
  sequence s_err_held;
    command_error [*5];
  endsequence
  sequence s_released;
    $fell(srst);
  endsequence
  property p_rdata_idle; !$past(rd_en) |-> rdata == 32'h0; endproperty
  property p_err_block; s_err_held |-> !start_reprint; endproperty
  property p_go_once; start_print |=> !start_print; endproperty
  property p_again_once; start_reprint |=> !start_reprint; endproperty
  property p_disp_once; dispense_go |=> !dispense_go; endproperty
  property p_trig_online; start_print || start_reprint || dispense_go |-> online_output;
  endproperty
  property p_rst_quiet; s_released |-> !(start_print || start_reprint || dispense_go);
  endproperty
  property p_rst_offline; s_released |-> ##1 !online_output; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
  a_err_block: assert property (p_err_block) else $error("reprint during error");
  a_go_once: assert property (p_go_once) else $error("print pulse too long");
  a_again_once: assert property (p_again_once) else $error("reprint pulse too long");
  a_disp_once: assert property (p_disp_once) else $error("dispense pulse too long");
  a_trig_online: assert property (p_trig_online) else $error("trigger while offline");
  a_rst_quiet: assert property (p_rst_quiet) else $error("trigger at reset release");
  a_rst_offline: assert property (p_rst_offline) else $error("online after reset");
endmodule // print_signal_ctrl_sva

bind print_signal_ctrl print_signal_ctrl_sva chk (
  .clk_sys(clk_sys), .srst(srst), .rd_en(rd_en), .rdata(rdata),
  .command_error(command_error), .online_output(online_output),
  .start_print(start_print), .start_reprint(start_reprint), .dispense_go(dispense_go)
);

//--- common/print_signal_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef PRINT_SIGNAL_REGS_VH
`define PRINT_SIGNAL_REGS_VH

// Clock and timing
`define CLK_FREQ_HZ 125000000
`define END_PULSE_MS 20
`define CYCLES_PER_MS (`CLK_FREQ_HZ / 1000)
`define MS_CNT_W 17
`define PULSE_CNT_W 5
`define MS_TICK_LAST 17'h1e847
`define END_PULSE_LAST 5'h13

// Register offsets
`define REG_CONFIG 4'h0
`define REG_HEAD_INTERVAL 4'h1
`define REG_PIN_MAP 4'h2
`define REG_STATUS 4'h3
`define REG_HEAD_COUNT 4'h4

// Config fields
`define CFG_EXT_PORT 0
`define CFG_END_TYPE_LO 1
`define CFG_END_TYPE_HI 2
`define CFG_EXT_REPRINT 3
`define CFG_CONT_PRINT 4
`define CFG_ENH_REPRINT 5
`define CFG_CONT_MODE 6
`define CFG_HEAD_MODE_LO 7
`define CFG_HEAD_MODE_HI 8
`define CFG_EXT_BACKFEED 9
`define CFG_AUTO_ONLINE 10
`define CFG_WIDTH 11
`define CFG_RESET 11'h000

// Pin map fields
`define PIN_READY_OPT 0
`define PIN_NINE_PIN 1
`define PIN_WIDTH 2
`define PIN_RESET 2'h0
`define AUTO_ONLINE_RESET 1'h0

// Status fields
`define ST_ONLINE 0
`define ST_PRINTING 1
`define ST_DONE 2
`define ST_READY_ASSIGNED 3
`define ST_BACKFEED_ACTIVE 4

// End waveform types
`define TYPE_END_LOW 2'h0
`define TYPE_END_HIGH 2'h1
`define TYPE_ACT_LOW 2'h2
`define TYPE_ACT_HIGH 2'h3

// Head check modes
`define HEAD_ALL 2'h0
`define HEAD_EVERY_N 2'h1
`define HEAD_START_END 2'h2

// Head interval
`define HEAD_INT_W 20
`define HEAD_INT_MIN 20'h00001
`define HEAD_INT_MAX 20'hf423f
`define HEAD_INT_RESET 20'h00001

`endif

//--- core/ms_tick.v
// Millisecond enable pulse divided from the system clock
`timescale 1ns/1ps
`include "print_signal_regs.vh"

module ms_tick (
  input wire clk_sys,
  input wire srst,
  output reg tick
);
  localparam [16:0] LAST = `MS_TICK_LAST;
  reg [16:0] count;

  always @(posedge clk_sys) begin
    if (srst) begin
      count <= 17'h00000;
      tick <= 1'b0;
    end else if (count == LAST) begin
      count <= 17'h00000;
      tick <= 1'b1;
    end else begin
      count <= count + 17'h00001;
      tick <= 1'b0;
    end
  end
endmodule // ms_tick

//--- core/print_signal_ctrl.v
// External print signal controller: print-done waveform, triggers, head check
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "print_signal_regs.vh"

module print_signal_ctrl (
  input wire clk_sys,
  input wire srst,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  input wire print_go_input,
  input wire print_again_input,
  input wire dispense_req_input,
  input wire print_start,
  input wire print_end,
  input wire quantity_remaining,
  input wire command_error,
  input wire online_toggle,
  input wire engine_ready,
  input wire at_home,
  output reg print_done_output,
  output reg online_output,
  output reg printer_ready_output,
  output reg home_position_output,
  output reg start_print,
  output reg start_reprint,
  output reg dispense_go,
  output reg head_check
);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  reg [`CFG_WIDTH-1:0] config_reg;
  reg [`HEAD_INT_W-1:0] head_interval;
  // Power-cycle settings start from their defaults and survive srst
  reg [`PIN_WIDTH-1:0] pin_map_pending = `PIN_RESET;
  reg auto_online_kept = `AUTO_ONLINE_RESET;
  reg [`PIN_WIDTH-1:0] pin_map_active;
  reg powered;
  reg online;

  wire cont_mode = config_reg[`CFG_CONT_MODE];
  wire ext_en = config_reg[`CFG_EXT_PORT] & cont_mode;
  wire [1:0] end_type = config_reg[`CFG_END_TYPE_HI:`CFG_END_TYPE_LO];
  wire ext_reprint = config_reg[`CFG_EXT_REPRINT];
  wire enh_reprint = config_reg[`CFG_ENH_REPRINT] & ext_reprint;
  wire cont_print = config_reg[`CFG_CONT_PRINT];
  wire [1:0] head_mode = config_reg[`CFG_HEAD_MODE_HI:`CFG_HEAD_MODE_LO];
  wire ext_backfeed = config_reg[`CFG_EXT_BACKFEED];
  wire ready_assigned = pin_map_active[`PIN_READY_OPT] & pin_map_active[`PIN_NINE_PIN];

  // Keep interval in its legal range; out-of-range writes are ignored
  wire [`HEAD_INT_W-1:0] wr_interval = wdata[`HEAD_INT_W-1:0];
  wire interval_ok = (wr_interval >= `HEAD_INT_MIN) && (wr_interval <= `HEAD_INT_MAX);

  always @(posedge clk_sys) begin
    if (srst) begin
      config_reg <= `CFG_RESET;
      head_interval <= `HEAD_INT_RESET;
    end else if (wr_en) begin
      case (addr)
        `REG_CONFIG: config_reg <= wdata[`CFG_WIDTH-1:0];
        `REG_HEAD_INTERVAL: begin
          if (interval_ok) begin
            head_interval <= wr_interval;
          end
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Power-cycle settings
  // ------------------------------------------------------------
  // Kept through srst, which stands for a power cycle; clearing them there
  // would leave the pin map and auto online with no effect at all.
  always @(posedge clk_sys) begin
    if (wr_en && !srst) begin
      if (addr == `REG_PIN_MAP) begin
        pin_map_pending <= wdata[`PIN_WIDTH-1:0];
      end
      if (addr == `REG_CONFIG) begin
        auto_online_kept <= wdata[`CFG_AUTO_ONLINE];
      end
    end
  end

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Inputs are held levels, so two stages and an edge detect suffice
  wire [3:0] raw_in = {online_toggle, dispense_req_input, print_again_input, print_go_input};
  wire [3:0] rise;
  genvar i;

  generate
    for (i = 0; i < 4; i = i + 1) begin : g_sync
      reg stage1;
      reg stage2;
      reg stage_prev;
      always @(posedge clk_sys) begin
        if (srst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
          stage_prev <= 1'b0;
        end else begin
          stage1 <= raw_in[i];
          stage2 <= stage1;
          stage_prev <= stage2;
        end
      end
      // Idle level is low, so no false edge follows reset
      assign rise[i] = stage2 & ~stage_prev;
    end
  endgenerate

  wire go_rise = rise[0];
  wire again_rise = rise[1];
  wire dispense_rise = rise[2];
  wire online_toggle_rise = rise[3];

  // ------------------------------------------------------------
  // Power-on capture
  // ------------------------------------------------------------
  // Pin map and online state latch once after reset release only, so
  // software edits wait for the next power cycle.
  always @(posedge clk_sys) begin
    if (srst) begin
      powered <= 1'b0;
      pin_map_active <= `PIN_RESET;
      online <= 1'b0;
    end else begin
      if (!powered) begin
        powered <= 1'b1;
        pin_map_active <= pin_map_pending;
        online <= auto_online_kept;
      end else if (online_toggle_rise) begin
        online <= ~online;
      end
    end
  end

  // ------------------------------------------------------------
  // Print and reprint triggers
  // ------------------------------------------------------------
  wire reprint_ok = ext_en & ext_reprint & ~command_error;
  wire next_start_reprint = again_rise & reprint_ok &
    (enh_reprint | ~quantity_remaining);
  wire next_start_print = go_rise & ext_en & cont_print & ~quantity_remaining;
  wire next_dispense = dispense_rise & ext_backfeed & online;

  always @(posedge clk_sys) begin
    if (srst) begin
      start_print <= 1'b0;
      start_reprint <= 1'b0;
      dispense_go <= 1'b0;
    end else begin
      start_print <= next_start_print & online;
      start_reprint <= next_start_reprint & online;
      dispense_go <= next_dispense;
    end
  end

  // ------------------------------------------------------------
  // Print-done waveform
  // ------------------------------------------------------------
  wire ms_en;
  reg printing;
  reg pulse_active;
  reg [4:0] pulse_ms;
  localparam [4:0] PULSE_LAST = `END_PULSE_LAST;

  ms_tick u_ms_tick (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick(ms_en)
  );

  always @(posedge clk_sys) begin
    if (srst) begin
      printing <= 1'b0;
      pulse_active <= 1'b0;
      pulse_ms <= 5'h00;
    end else begin
      if (print_start) begin
        printing <= 1'b1;
      end else if (print_end) begin
        printing <= 1'b0;
      end
      // Completion always reloads, so back-to-back prints stretch the pulse
      if (print_end) begin
        pulse_active <= 1'b1;
        pulse_ms <= 5'h00;
      end else if (pulse_active && ms_en) begin
        if (pulse_ms == PULSE_LAST) begin
          pulse_active <= 1'b0;
        end else begin
          pulse_ms <= pulse_ms + 5'h01;
        end
      end
    end
  end

  reg next_done;
  always @* begin
    case (end_type)
      `TYPE_END_LOW: next_done = ~pulse_active;
      `TYPE_END_HIGH: next_done = pulse_active;
      `TYPE_ACT_LOW: next_done = ~printing;
      `TYPE_ACT_HIGH: next_done = printing;
      default: next_done = 1'b0;
    endcase
    if (!ext_en) begin
      next_done = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Head check scheduling
  // ------------------------------------------------------------
  reg [`HEAD_INT_W-1:0] media_count;
  reg next_head;
  wire interval_hit = (media_count + 20'h00001) >= head_interval;

  always @* begin
    case (head_mode)
      `HEAD_ALL: next_head = print_end;
      `HEAD_EVERY_N: next_head = print_end & interval_hit;
      `HEAD_START_END: next_head = print_start | print_end | next_dispense;
      default: next_head = 1'b0;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      media_count <= {`HEAD_INT_W{1'b0}};
    end else if (head_mode != `HEAD_EVERY_N) begin
      media_count <= {`HEAD_INT_W{1'b0}};
    end else if (print_end) begin
      media_count <= interval_hit ? {`HEAD_INT_W{1'b0}} : media_count + 20'h00001;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      print_done_output <= 1'b0;
      online_output <= 1'b0;
      printer_ready_output <= 1'b0;
      home_position_output <= 1'b0;
      head_check <= 1'b0;
    end else begin
      print_done_output <= next_done;
      online_output <= online;
      printer_ready_output <= ready_assigned & online & engine_ready;
      home_position_output <= ext_backfeed & at_home;
      head_check <= next_head;
    end
  end

  // ------------------------------------------------------------
  // Register read
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (srst) begin
      rdata <= 32'h00000000;
    end else if (rd_en) begin
      case (addr)
        `REG_CONFIG: rdata <= {21'h000000, config_reg};
        `REG_HEAD_INTERVAL: rdata <= {12'h000, head_interval};
        `REG_PIN_MAP: rdata <= {30'h00000000, pin_map_pending};
        `REG_STATUS: rdata <= {27'h0000000, ext_backfeed, ready_assigned,
          pulse_active, printing, online};
        `REG_HEAD_COUNT: rdata <= {12'h000, media_count};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule // print_signal_ctrl
